// [hdl/fault_action_manager.sv]
`timescale 1ns/1ps
`default_nettype none

module fault_action_manager
  import fault_pkg::*;
#(
  parameter int DEPTH = fault_pkg::TABLE_DEPTH
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic rack_lost,
  input wire logic io_controller_lost,
  input wire logic io_module_lost,
  input wire logic option_module_lost,
  input wire logic io_controller_fault,
  input wire logic config_mismatch,
  input wire logic backplane_bus_error,
  input wire logic fan_fault,
  input wire logic overtemp,
  input wire logic ecc_single_error,
  input wire logic ecc_multi_error,
  input wire logic [fault_pkg::NUM_SRC-1:0] action_fatal_cfg,
  input wire logic cpu_running,
  input wire logic service_call_stop,
  input wire logic run_request,
  input wire logic rack_power_cycle,
  input wire logic main_rack_power_cycle,
  input wire logic config_match_ok,
  input wire logic ctrl_table_clear,
  input wire logic io_table_clear,
  input wire logic [$clog2(DEPTH)-1:0] ctrl_rd_index,
  input wire logic [$clog2(DEPTH)-1:0] io_rd_index,
  output logic rack_lost_flag,
  output logic io_controller_lost_flag,
  output logic io_module_lost_flag,
  output logic option_module_lost_flag,
  output logic io_controller_fault_flag,
  output logic config_mismatch_flag,
  output logic backplane_bus_error_flag,
  output logic fan_fault_flag,
  output logic overtemp_flag,
  output logic stop_faulted_q,
  output logic [fault_pkg::ENTRY_W-1:0] ctrl_entry_q,
  output logic [fault_pkg::ENTRY_W-1:0] io_entry_q,
  output logic [$clog2(DEPTH):0] ctrl_count_q,
  output logic [$clog2(DEPTH):0] io_count_q,
  output logic ctrl_overflow_q,
  output logic io_overflow_q,
  output logic [$clog2(DEPTH):0] ctrl_capacity_q,
  output logic [$clog2(DEPTH):0] io_capacity_q
);

  import fault_pkg::*;

  // ----------------------------------------------------------------
  // Fault collection and action selection
  // ----------------------------------------------------------------
  logic [NUM_SRC-1:0] report;
  logic [NUM_SRC-1:0] eff_fatal;
  logic [NUM_SRC-1:0] fatal_hit;
  logic [NUM_SRC*ENTRY_W-1:0] entries;
  logic [NUM_SRC-1:0] ctrl_log;
  logic [NUM_SRC-1:0] io_log;
  logic loss_fatal_pending;
  logic [3:0] loss_stop_d;
  logic [3:0] loss_stop_q;
  logic [3:0] loss_flags;
  logic [3:0] loss_clear;
  logic ctrl_clear;
  logic io_clear;
  logic stop_d;
  cpu_state_t state_q;
  cpu_state_t state_d;

  assign report = {ecc_multi_error, ecc_single_error, overtemp, fan_fault,
                   backplane_bus_error, config_mismatch, io_controller_fault,
                   option_module_lost, io_module_lost, io_controller_lost, rack_lost};

  // Mismatch while running is forced diagnostic; multi-bit ECC is always fatal.
  always_comb
  begin
    eff_fatal = action_fatal_cfg;
    eff_fatal[SRC_CFG] = action_fatal_cfg[SRC_CFG] & ~cpu_running;
    eff_fatal[SRC_ECC2] = 1'b1;
  end

  assign fatal_hit = report & eff_fatal;

  assign entries = {GRP_CPU_HW, CODE_ECC_MULTI,
                    GRP_ECC_SINGLE, CODE_NONE,
                    GRP_OVERTEMP, CODE_OVERTEMP,
                    GRP_FAN, CODE_NONE,
                    GRP_BUS_ERROR, CODE_NONE,
                    GRP_CFG_MISMATCH, CODE_NONE,
                    GRP_IOC_FAULT, CODE_NONE,
                    GRP_OPT_LOST, CODE_NONE,
                    GRP_IOM_LOST, CODE_NONE,
                    GRP_IOC_LOST, CODE_NONE,
                    GRP_RACK_LOST, CODE_NONE};

  assign ctrl_log = report & CTRL_TABLE_SRC;
  assign io_log = report & ~CTRL_TABLE_SRC;
  assign ctrl_clear = ctrl_table_clear;
  assign io_clear = io_table_clear;

  // ----------------------------------------------------------------
  // Loss-of-module stop bookkeeping
  // ----------------------------------------------------------------
  // A fatal loss stop is held only while its I/O table entry survives, so a
  // table clear in the same cycle as the stop cancels it before it lands.
  assign loss_stop_d = io_clear ? 4'h0 : (loss_stop_q | fatal_hit[3:0]);
  assign loss_fatal_pending = |(fatal_hit[3:0]) & ~io_clear;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      loss_stop_q <= 4'h0;
    else
      loss_stop_q <= loss_stop_d;
  end

  // ----------------------------------------------------------------
  // Run state
  // ----------------------------------------------------------------
  assign stop_d = loss_fatal_pending | (|fatal_hit[NUM_SRC-1:4]) | service_call_stop;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      RUN_ST:
        if (stop_d)
          state_d = STOP_FAULTED_ST;
      STOP_FAULTED_ST:
        if (run_request && !stop_d)
          state_d = RUN_ST;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= RUN_ST;
      stop_faulted_q <= 1'b0;
      ctrl_capacity_q <= '0;
      io_capacity_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      stop_faulted_q <= (state_d == STOP_FAULTED_ST);
      ctrl_capacity_q <= ($clog2(DEPTH)+1)'(DEPTH);
      io_capacity_q <= ($clog2(DEPTH)+1)'(DEPTH);
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  assign loss_clear = {4{rack_power_cycle}};

  sticky_flag u_rack (.sys_clk(sys_clk), .rst_n(rst_n), .set_i(rack_lost),
    .clear_i(loss_clear[0]), .flag_q(rack_lost_flag));
  sticky_flag u_ioc (.sys_clk(sys_clk), .rst_n(rst_n), .set_i(io_controller_lost),
    .clear_i(loss_clear[1]), .flag_q(io_controller_lost_flag));
  sticky_flag u_iom (.sys_clk(sys_clk), .rst_n(rst_n), .set_i(io_module_lost),
    .clear_i(loss_clear[2]), .flag_q(io_module_lost_flag));
  sticky_flag u_opt (.sys_clk(sys_clk), .rst_n(rst_n), .set_i(option_module_lost),
    .clear_i(loss_clear[3]), .flag_q(option_module_lost_flag));
  sticky_flag u_iocf (.sys_clk(sys_clk), .rst_n(rst_n), .set_i(io_controller_fault),
    .clear_i(rack_power_cycle & config_match_ok), .flag_q(io_controller_fault_flag));
  sticky_flag u_cfg (.sys_clk(sys_clk), .rst_n(rst_n), .set_i(config_mismatch),
    .clear_i(config_match_ok), .flag_q(config_mismatch_flag));
  sticky_flag u_bus (.sys_clk(sys_clk), .rst_n(rst_n), .set_i(backplane_bus_error),
    .clear_i(main_rack_power_cycle), .flag_q(backplane_bus_error_flag));
  sticky_flag u_fan (.sys_clk(sys_clk), .rst_n(rst_n), .set_i(fan_fault),
    .clear_i(ctrl_clear), .flag_q(fan_fault_flag));
  sticky_flag u_temp (.sys_clk(sys_clk), .rst_n(rst_n), .set_i(overtemp),
    .clear_i(ctrl_clear), .flag_q(overtemp_flag));

  // ----------------------------------------------------------------
  // Fault tables
  // ----------------------------------------------------------------
  fault_table #(.DEPTH(DEPTH), .NSRC(NUM_SRC), .EW(ENTRY_W)) u_ctrl_tbl (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clear_i(ctrl_clear),
    .log_i(ctrl_log),
    .entry_i(entries),
    .rd_index(ctrl_rd_index),
    .rd_entry_q(ctrl_entry_q),
    .count_q(ctrl_count_q),
    .overflow_q(ctrl_overflow_q)
  );

  fault_table #(.DEPTH(DEPTH), .NSRC(NUM_SRC), .EW(ENTRY_W)) u_io_tbl (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clear_i(io_clear),
    .log_i(io_log),
    .entry_i(entries),
    .rd_index(io_rd_index),
    .rd_entry_q(io_entry_q),
    .count_q(io_count_q),
    .overflow_q(io_overflow_q)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence fatal_event_s;
    |(fatal_hit[NUM_SRC-1:4]);
  endsequence

  a_fatal_stops: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fatal_event_s |=> stop_faulted_q) else $error("Fatal fault did not stop");
  a_diag_keeps_run: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!stop_faulted_q && report != 0 && fatal_hit == 0 && !service_call_stop && state_q == RUN_ST)
    |=> !stop_faulted_q) else $error("Diagnostic fault stopped CPU");
  a_svc_stop: assert property (@(posedge sys_clk) disable iff (!rst_n)
    service_call_stop |=> stop_faulted_q) else $error("Service call did not stop");
  a_cfg_run_diag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cpu_running && config_mismatch && fatal_hit == 0 && !service_call_stop && state_q == RUN_ST)
    |=> !stop_faulted_q) else $error("Running mismatch stopped CPU");
  a_ecc_multi_stop: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ecc_multi_error |=> stop_faulted_q && ctrl_count_q != 0) else $error("Multi-bit ECC not fatal");
  a_loss_clear_nostop: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (io_clear && state_q == RUN_ST && !(|fatal_hit[NUM_SRC-1:4]) && !service_call_stop)
    |=> !stop_faulted_q) else $error("Cleared loss still stopped");
  a_rack_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rack_lost |=> rack_lost_flag) else $error("Rack flag not set");
  a_flag_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (backplane_bus_error_flag && !main_rack_power_cycle) |=> backplane_bus_error_flag)
    else $error("Bus error flag dropped");
  a_fan_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ctrl_clear && !fan_fault) |=> !fan_fault_flag) else $error("Fan flag not cleared");
  a_table_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctrl_count_q <= ($clog2(DEPTH)+1)'(DEPTH) && io_count_q <= ($clog2(DEPTH)+1)'(DEPTH))
    else $error("Table over capacity");
  a_temp_logged: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (overtemp && !ctrl_clear && ctrl_count_q < 7'd60) |=> ctrl_count_q > $past(ctrl_count_q))
    else $error("Overtemp not logged");

endmodule

`default_nettype wire

// [shared/fault_pkg.sv]
package fault_pkg;

  // ----------------------------------------------------------------
  // Fault groups and codes
  // ----------------------------------------------------------------
  localparam int NUM_SRC = 11;
  localparam logic [7:0] GRP_RACK_LOST = 8'h01;
  localparam logic [7:0] GRP_IOC_LOST = 8'h02;
  localparam logic [7:0] GRP_IOM_LOST = 8'h03;
  localparam logic [7:0] GRP_OPT_LOST = 8'h04;
  localparam logic [7:0] GRP_IOC_FAULT = 8'h09;
  localparam logic [7:0] GRP_CFG_MISMATCH = 8'h0B;
  localparam logic [7:0] GRP_BUS_ERROR = 8'h0C;
  localparam logic [7:0] GRP_CPU_HW = 8'h0D;
  localparam logic [7:0] GRP_FAN = 8'h17;
  localparam logic [7:0] GRP_OVERTEMP = 8'h18;
  localparam logic [7:0] GRP_ECC_SINGLE = 8'h26;
  localparam logic [7:0] CODE_OVERTEMP = 8'h01;
  localparam logic [7:0] CODE_ECC_MULTI = 8'hA9;
  localparam logic [7:0] CODE_NONE = 8'h00;

  // Source index order used on every per-source vector.
  localparam int SRC_RACK = 0;
  localparam int SRC_IOC = 1;
  localparam int SRC_IOM = 2;
  localparam int SRC_OPT = 3;
  localparam int SRC_IOCF = 4;
  localparam int SRC_CFG = 5;
  localparam int SRC_BUS = 6;
  localparam int SRC_FAN = 7;
  localparam int SRC_TEMP = 8;
  localparam int SRC_ECC1 = 9;
  localparam int SRC_ECC2 = 10;

  // Default actions, bit set means fatal.
  localparam logic [NUM_SRC-1:0] ACTION_RESET = 11'h460;

  // Controller table gets CPU-side faults, the I/O table the rest.
  localparam logic [NUM_SRC-1:0] CTRL_TABLE_SRC = 11'h7A0;

  localparam int TABLE_DEPTH = 64;
  localparam int ENTRY_W = 16;

  typedef enum logic [1:0] {
    RUN_ST = 2'b01,
    STOP_FAULTED_ST = 2'b10
  } cpu_state_t;

endpackage

// [hdl/sticky_flag.sv]
`timescale 1ns/1ps
`default_nettype none

module sticky_flag
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic set_i,
  input wire logic clear_i,
  output logic flag_q
);

  // A set in the cycle of a clear wins so no event is lost.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      flag_q <= 1'b0;
    else if (set_i)
      flag_q <= 1'b1;
    else if (clear_i)
      flag_q <= 1'b0;
  end

endmodule

`default_nettype wire

// [hdl/fault_table.sv]
`timescale 1ns/1ps
`default_nettype none

module fault_table
#(
  parameter int DEPTH = 64,
  parameter int NSRC = 11,
  parameter int EW = 16
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clear_i,
  input wire logic [NSRC-1:0] log_i,
  input wire logic [NSRC*EW-1:0] entry_i,
  input wire logic [$clog2(DEPTH)-1:0] rd_index,
  output logic [EW-1:0] rd_entry_q,
  output logic [$clog2(DEPTH):0] count_q,
  output logic overflow_q
);

  localparam int CW = $clog2(DEPTH) + 1;

  logic [EW-1:0] mem_q [DEPTH];
  logic [CW-1:0] slot [NSRC+1];
  logic [NSRC-1:0] fits;
  logic [CW-1:0] start;
  logic drop;

  // A clear empties the table first, so reports of the same cycle are still kept.
  assign start = clear_i ? '0 : count_q;

  // Several reports in one cycle take consecutive slots in source order.
  always_comb
  begin
    slot[0] = start;
    fits = '0;
    for (int s = 0; s < NSRC; s++)
    begin
      fits[s] = log_i[s] && (slot[s] < CW'(DEPTH));
      slot[s+1] = slot[s] + CW'(fits[s]);
    end
  end

  assign drop = |(log_i & ~fits);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q <= '0;
      overflow_q <= 1'b0;
      rd_entry_q <= '0;
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= '0;
    end
    else
    begin
      rd_entry_q <= mem_q[rd_index];
      count_q <= slot[NSRC];
      overflow_q <= (overflow_q & ~clear_i) | drop;
      for (int s = 0; s < NSRC; s++)
        if (fits[s])
          mem_q[slot[s][CW-2:0]] <= entry_i[s*EW +: EW];
    end
  end

endmodule

`default_nettype wire

// [sim/fault_source_model.sv]
`timescale 1ns/1ps
`default_nettype none

module fault_source_model
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [10:0] fire,
  output logic [10:0] fault_q
);
  // A requested event leaves one cycle later as a registered copy, so a held request is seen as a level.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      fault_q <= '0;
    else
      fault_q <= fire;
  end
endmodule

`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ps
`default_nettype none

module tb;
  import fault_pkg::*;
  logic sys_clk, rst_n, cpu_running, stop, cov, iov;
  logic [10:0] fire, fq, cfg;
  logic [6:0] ctl, cc, ic, ccap, icap;
  logic [5:0] ci, ii;
  logic [8:0] fl, ef;
  logic [15:0] ce, ie;
  logic es, ecv, eiv;
  int err_count = 0, check_count = 0, cyc = 0, ecc_n, eio_n;
  localparam logic [15:0] ENT [0:10] = '{16'h0100, 16'h0200, 16'h0300, 16'h0400, 16'h0900, 16'h0B00,
    16'h0C00, 16'h1700, 16'h1801, 16'h2600, 16'h0DA9};

  fault_source_model src (.sys_clk(sys_clk), .rst_n(rst_n), .fire(fire), .fault_q(fq));

  fault_action_manager DUT (.sys_clk(sys_clk), .rst_n(rst_n), .rack_lost(fq[0]), .io_controller_lost(fq[1]),
    .io_module_lost(fq[2]), .option_module_lost(fq[3]), .io_controller_fault(fq[4]), .config_mismatch(fq[5]),
    .backplane_bus_error(fq[6]), .fan_fault(fq[7]), .overtemp(fq[8]), .ecc_single_error(fq[9]),
    .ecc_multi_error(fq[10]), .action_fatal_cfg(cfg), .cpu_running(cpu_running), .service_call_stop(ctl[0]),
    .run_request(ctl[1]), .rack_power_cycle(ctl[2]), .main_rack_power_cycle(ctl[3]), .config_match_ok(ctl[4]),
    .ctrl_table_clear(ctl[5]), .io_table_clear(ctl[6]), .ctrl_rd_index(ci), .io_rd_index(ii),
    .rack_lost_flag(fl[0]), .io_controller_lost_flag(fl[1]), .io_module_lost_flag(fl[2]),
    .option_module_lost_flag(fl[3]), .io_controller_fault_flag(fl[4]), .config_mismatch_flag(fl[5]),
    .backplane_bus_error_flag(fl[6]), .fan_fault_flag(fl[7]), .overtemp_flag(fl[8]), .stop_faulted_q(stop),
    .ctrl_entry_q(ce), .io_entry_q(ie), .ctrl_count_q(cc), .io_count_q(ic), .ctrl_overflow_q(cov),
    .io_overflow_q(iov), .ctrl_capacity_q(ccap), .io_capacity_q(icap));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Faults pass the source model, so controls are launched one edge later to meet them at the same edge.
  task automatic step(input logic [10:0] fv, input logic [6:0] cv);
    logic [10:0] eff;
    logic [8:0] clr;
    logic cause;
    @(posedge sys_clk);
    fire <= fv;
    @(posedge sys_clk);
    fire <= '0;
    ctl <= cv;
    @(posedge sys_clk);
    ctl <= '0;
    #1;
    eff = cfg | 11'h400;
    if (cpu_running)
      eff[5] = 1'b0;
    if (cv[6])
      eff[3:0] = 4'h0;
    cause = (|(fv & eff)) | cv[0];
    clr = {{2{cv[5]}}, cv[3], cv[4], cv[2] & cv[4], {4{cv[2]}}};
    ef = (ef & ~clr) | fv[8:0];
    es = cause | (es & ~cv[1]);
    ecc_n = (cv[5] ? 0 : ecc_n) + $countones(fv & CTRL_TABLE_SRC);
    eio_n = (cv[6] ? 0 : eio_n) + $countones(fv & ~CTRL_TABLE_SRC);
    ecv = (ecv & ~cv[5]) | (ecc_n > 64);
    eiv = (eiv & ~cv[6]) | (eio_n > 64);
    if (ecc_n > 64)
      ecc_n = 64;
    if (eio_n > 64)
      eio_n = 64;
    chk(16'(fl), 16'(ef));
    chk(16'(stop), 16'(es));
    chk(16'(cc), 16'(ecc_n));
    chk(16'(ic), 16'(eio_n));
    chk(16'(cov), 16'(ecv));
    chk(16'(iov), 16'(eiv));
  endtask

  task automatic rd(input logic [5:0] c, input logic [5:0] i);
    @(posedge sys_clk);
    ci <= c;
    ii <= i;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    ef = '0;
    es = 1'b0;
    ecv = 1'b0;
    eiv = 1'b0;
    ecc_n = 0;
    eio_n = 0;
    @(posedge sys_clk);
    #1;
    chk(16'(ccap), 16'h0040);
    chk(16'(icap), 16'h0040);
    chk(16'(fl), 16'h0000);
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      stop_test();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    fire = '0;
    ctl = '0;
    cfg = 11'h460;
    cpu_running = 1'b0;
    ci = '0;
    ii = '0;
    void'($urandom(32'hD154C5A3));
    do_reset();
    step(11'h000, 7'h60);
    for (int i = 0; i < 11; i++)
    begin
      step(11'h001 << i, 7'h00);
      rd(6'(ecc_n - 1), 6'(eio_n - 1));
      chk(CTRL_TABLE_SRC[i] ? ce : ie, ENT[i]);
      step(11'h000, 7'h02);
    end
    step(11'h000, 7'h7C);
    step(11'h540, 7'h00);
    rd(6'h00, 6'h00);
    chk(ce, 16'h1801);
    chk(ie, 16'h0C00);
    rd(6'h01, 6'h00);
    chk(ce, 16'h0DA9);
    step(11'h000, 7'h08);
    @(posedge sys_clk) cpu_running <= 1'b1;
    step(11'h020, 7'h02);
    @(posedge sys_clk) cpu_running <= 1'b0;
    step(11'h020, 7'h10);
    step(11'h000, 7'h01);
    step(11'h000, 7'h03);
    step(11'h000, 7'h02);
    @(posedge sys_clk) cfg <= 11'h461;
    step(11'h001, 7'h40);
    step(11'h000, 7'h40);
    step(11'h001, 7'h00);
    step(11'h000, 7'h06);
    @(posedge sys_clk) cfg <= 11'h460;
    step(11'h000, 7'h40);
    repeat (65) step(11'h004, 7'h00);
    chk(16'(iov), 16'h0001);
    repeat (150)
    begin
      @(posedge sys_clk);
      cfg <= 11'($urandom);
      cpu_running <= 1'($urandom);
      step(11'($urandom & $urandom), 7'($urandom & 32'h1F));
    end
    do_reset();
    stop_test();
  end
endmodule

`default_nettype wire
